// ===== scd_map.svh
// Constants of the smart card serial command decoder.
// Assumes inclusion by the package and the decoder only.
`ifndef SCD_MAP_SVH
`define SCD_MAP_SVH

// ----------------------------------------
// Command byte layout
// ----------------------------------------
`define SCD_CMD_W        8
`define SCD_PFX_HI       7
`define SCD_PFX_LO       5
`define SCD_RST_BIT      4
`define SCD_CLK_HI       3
`define SCD_CLK_LO       2
`define SCD_VCC_HI       1
`define SCD_VCC_LO       0
`define SCD_DATA_BIT     2
`define SCD_AUXA_BIT     1
`define SCD_AUXB_BIT     0
`define SCD_PFX_DED      3'h4
`define SCD_PFX_CFG      3'h5
`define SCD_PFX_SYNC     3'h6
`define SCD_PFX_RSV      3'h7

// ----------------------------------------
// Configuration codes under prefix 101
// ----------------------------------------
`define SCD_CFG_DET_NO   5'h00
`define SCD_CFG_DET_NC   5'h01
`define SCD_CFG_SPECIAL  5'h02
`define SCD_CFG_NORMAL   5'h03
`define SCD_CFG_SLOW     5'h04
`define SCD_CFG_FAST     5'h05

// ----------------------------------------
// Field codes, supply reset value and serial bit limits
// ----------------------------------------
`define SCD_CK_CODE_LOW  2'h0
`define SCD_CK_CODE_DIV1 2'h1
`define SCD_CK_CODE_DIV2 2'h2
`define SCD_CK_CODE_DIV4 2'h3
`define SCD_VCC_OFF      2'h0
`define SCD_BIT_LAST     3'h7
`define SCD_RB_DRIVE_TOP 3'h4

`endif

// ===== scd_pkg.sv
// Types of the smart card serial command decoder.
// Assumes scd_map.svh is on the include path.
`include "scd_map.svh"

package scd_pkg;

  // ----------------------------------------
  // Decoded command kinds and clock modes
  // ----------------------------------------
  typedef enum logic [2:0] {
    SCD_CMD_NONE,
    SCD_CMD_PROG,
    SCD_CMD_SYNC,
    SCD_CMD_CFG,
    SCD_CMD_RSV
  } scd_cmd_t;

  typedef enum logic [2:0] {
    SCD_CK_LOW,
    SCD_CK_DIV1,
    SCD_CK_DIV2,
    SCD_CK_DIV4,
    SCD_CK_HOLD
  } scd_clk_t;

  // ----------------------------------------
  // Hidden configuration
  // ----------------------------------------
  typedef struct packed {
    logic det_nc;
    logic edge_special;
    logic slow_slopes;
  } scd_cfg_t;

endpackage : scd_pkg

// ===== scd_decoder.sv
// Smart card serial command decoder: serial port, command decode, card pins.
// Assumes spi pins and card inputs are synchronous to clk; master_clk_in is slower than clk/2.
`include "scd_map.svh"

module scd_decoder (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       spi_cs_n,
  input  wire logic       spi_clk,
  input  wire logic       spi_mosi,
  output logic            spi_miso,
  output logic            spi_miso_oe,
  input  wire logic       single_slot_bank,
  input  wire logic       master_clk_in,
  input  wire logic       card_detect_in,
  input  wire logic       power_ok_in,
  output logic            card_reset_out,
  output logic            card_clock_out,
  output logic [1:0]      card_supply,
  output logic            slow_clock_slopes,
  input  wire logic       card_data_line_in,
  output logic            card_data_line_out,
  output logic            card_data_line_oe,
  input  wire logic       aux_pin_a_strap_in,
  output logic            aux_pin_a_strap_out,
  output logic            aux_pin_a_strap_oe,
  input  wire logic       aux_pin_b_strap_in,
  output logic            aux_pin_b_strap_out,
  output logic            aux_pin_b_strap_oe
);

  // ----------------------------------------
  // Command decode.
  // ----------------------------------------
  function automatic scd_pkg::scd_cmd_t scd_decode(
    input logic [7:0] cmd,
    input logic       single,
    input logic       strap_a,
    input logic       strap_b
  );
    logic [2:0] pfx;
    pfx = cmd[`SCD_PFX_HI:`SCD_PFX_LO];
    scd_decode = scd_pkg::SCD_CMD_NONE;
    if (pfx == `SCD_PFX_CFG) begin
      scd_decode = scd_pkg::SCD_CMD_CFG;
    end else if (pfx == `SCD_PFX_RSV) begin
      scd_decode = scd_pkg::SCD_CMD_RSV;
    end else if (single) begin
      if (pfx == `SCD_PFX_DED) begin
        scd_decode = scd_pkg::SCD_CMD_PROG;
      end else if (pfx == `SCD_PFX_SYNC) begin
        scd_decode = scd_pkg::SCD_CMD_SYNC;
      end
    end else if (!cmd[`SCD_PFX_HI] && cmd[6] == strap_b && cmd[5] == strap_a) begin
      scd_decode = scd_pkg::SCD_CMD_PROG;
    end
  endfunction : scd_decode

  // ----------------------------------------
  // Serial port.
  // ----------------------------------------
  logic       sclk_prev_reg, sclk_prev_next;
  logic       cs_prev_reg,   cs_prev_next;
  logic [7:0] rx_reg,        rx_next;
  logic [7:0] tx_reg,        tx_next;
  logic [2:0] cnt_reg,       cnt_next;
  logic [2:0] idx_reg,       idx_next;
  logic       got_reg,       got_next;
  logic       valid_reg,     valid_next;
  logic [7:0] cmd_reg,       cmd_next;
  logic       miso_next,     miso_oe_next;
  logic       rise, fall, shift_edge, sample_edge;
  logic [7:0] readback;
  logic       inserted;

  scd_pkg::scd_cfg_t cfg_reg, cfg_next;

  always_comb begin
    inserted = cfg_reg.det_nc ? card_detect_in : !card_detect_in;
    readback = {3'h0,
                cfg_reg.edge_special ? card_detect_in : inserted,
                card_data_line_in, aux_pin_a_strap_in,
                aux_pin_b_strap_in, power_ok_in};
  end

  always_comb begin
    rise           = spi_clk && !sclk_prev_reg;
    fall           = !spi_clk && sclk_prev_reg;
    shift_edge     = cfg_reg.edge_special ? rise : fall;
    sample_edge    = cfg_reg.edge_special ? fall : rise;
    sclk_prev_next = spi_clk;
    cs_prev_next   = spi_cs_n;
    rx_next        = rx_reg;
    tx_next        = tx_reg;
    cnt_next       = cnt_reg;
    idx_next       = idx_reg;
    got_next       = got_reg;
    valid_next     = 1'b0;
    cmd_next       = cmd_reg;
    miso_next      = spi_miso;
    miso_oe_next   = 1'b0;
    if (spi_cs_n) begin
      cnt_next = 3'h0;
      got_next = 1'b0;
    end else if (cs_prev_reg) begin
      tx_next  = readback;
      idx_next = `SCD_BIT_LAST;
      cnt_next = 3'h0;
      got_next = 1'b0;
    end else begin
      if (sample_edge) begin
        rx_next  = {rx_reg[6:0], spi_mosi};
        cnt_next = cnt_reg + 3'h1;
        got_next = 1'b1;
        if (cnt_reg == `SCD_BIT_LAST) begin
          valid_next = 1'b1;
          cmd_next   = {rx_reg[6:0], spi_mosi};
        end
      end
      if (shift_edge && got_reg) begin
        tx_next  = {tx_reg[6:0], 1'b0};
        idx_next = idx_reg - 3'h1;
      end
    end
    if (!spi_cs_n) begin
      miso_next    = tx_next[7];
      miso_oe_next = !cs_prev_reg && idx_next <= `SCD_RB_DRIVE_TOP;
      if (cs_prev_reg) begin
        miso_oe_next = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_prev_reg <= 1'b1;
      cs_prev_reg   <= 1'b1;
      rx_reg        <= 8'h00;
      tx_reg        <= 8'h00;
      cnt_reg       <= 3'h0;
      idx_reg       <= 3'h0;
      got_reg       <= 1'b0;
      valid_reg     <= 1'b0;
      cmd_reg       <= 8'h00;
      spi_miso      <= 1'b0;
      spi_miso_oe   <= 1'b0;
    end else begin
      sclk_prev_reg <= sclk_prev_next;
      cs_prev_reg   <= cs_prev_next;
      rx_reg        <= rx_next;
      tx_reg        <= tx_next;
      cnt_reg       <= cnt_next;
      idx_reg       <= idx_next;
      got_reg       <= got_next;
      valid_reg     <= valid_next;
      cmd_reg       <= cmd_next;
      spi_miso      <= miso_next;
      spi_miso_oe   <= miso_oe_next;
    end
  end

  // ----------------------------------------
  // Command execution.
  // ----------------------------------------
  scd_pkg::scd_cmd_t kind;
  scd_pkg::scd_clk_t ck_reg, ck_next;
  logic [1:0] supply_next;
  logic       rst_next, sync_reg, sync_next;
  logic       data_next, auxa_next, auxb_next, hold_reg, hold_next;

  always_comb begin
    kind        = valid_reg ? scd_decode(cmd_reg, single_slot_bank,
                                         aux_pin_a_strap_in, aux_pin_b_strap_in)
                            : scd_pkg::SCD_CMD_NONE;
    cfg_next    = cfg_reg;
    ck_next     = ck_reg;
    supply_next = card_supply;
    rst_next    = card_reset_out;
    sync_next   = sync_reg;
    data_next   = card_data_line_out;
    auxa_next   = aux_pin_a_strap_out;
    auxb_next   = aux_pin_b_strap_out;
    hold_next   = hold_reg;
    case (kind)
      scd_pkg::SCD_CMD_PROG: begin
        rst_next    = cmd_reg[`SCD_RST_BIT];
        supply_next = cmd_reg[`SCD_VCC_HI:`SCD_VCC_LO];
        case (cmd_reg[`SCD_CLK_HI:`SCD_CLK_LO])
          `SCD_CK_CODE_LOW:  ck_next = scd_pkg::SCD_CK_LOW;
          `SCD_CK_CODE_DIV1: ck_next = scd_pkg::SCD_CK_DIV1;
          `SCD_CK_CODE_DIV2: ck_next = scd_pkg::SCD_CK_DIV2;
          default:           ck_next = scd_pkg::SCD_CK_DIV4;
        endcase
      end
      scd_pkg::SCD_CMD_SYNC: begin
        rst_next  = cmd_reg[`SCD_RST_BIT];
        ck_next   = scd_pkg::SCD_CK_HOLD;
        hold_next = cmd_reg[`SCD_CLK_HI];
        data_next = cmd_reg[`SCD_DATA_BIT];
        auxa_next = cmd_reg[`SCD_AUXA_BIT];
        auxb_next = cmd_reg[`SCD_AUXB_BIT];
        sync_next = 1'b1;
      end
      scd_pkg::SCD_CMD_CFG: begin
        rst_next = 1'b0;
        if (!cmd_reg[`SCD_RST_BIT]) begin
          case (cmd_reg[4:0])
            `SCD_CFG_DET_NO:  cfg_next.det_nc       = 1'b0;
            `SCD_CFG_DET_NC:  cfg_next.det_nc       = 1'b1;
            `SCD_CFG_SPECIAL: cfg_next.edge_special = 1'b1;
            `SCD_CFG_NORMAL:  cfg_next.edge_special = 1'b0;
            `SCD_CFG_SLOW:    cfg_next.slow_slopes  = 1'b1;
            `SCD_CFG_FAST:    cfg_next.slow_slopes  = 1'b0;
            default:          cfg_next              = cfg_reg;
          endcase
        end
      end
      scd_pkg::SCD_CMD_RSV: begin
        rst_next = cmd_reg[`SCD_RST_BIT];
      end
      default: begin
        rst_next = card_reset_out;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_reg             <= '{det_nc: 1'b0, edge_special: 1'b1, slow_slopes: 1'b1};
      ck_reg              <= scd_pkg::SCD_CK_LOW;
      card_supply         <= `SCD_VCC_OFF;
      card_reset_out      <= 1'b0;
      sync_reg            <= 1'b0;
      hold_reg            <= 1'b0;
      card_data_line_out  <= 1'b0;
      aux_pin_a_strap_out <= 1'b0;
      aux_pin_b_strap_out <= 1'b0;
    end else begin
      cfg_reg             <= cfg_next;
      ck_reg              <= ck_next;
      card_supply         <= supply_next;
      card_reset_out      <= rst_next;
      sync_reg            <= sync_next;
      hold_reg            <= hold_next;
      card_data_line_out  <= data_next;
      aux_pin_a_strap_out <= auxa_next;
      aux_pin_b_strap_out <= auxb_next;
    end
  end

  // ----------------------------------------
  // Card clock and pin drivers.
  // ----------------------------------------
  logic       mclk_prev_reg;
  logic [1:0] div_reg, div_next;
  logic       cko_next;

  always_comb begin
    div_next = div_reg;
    if (master_clk_in && !mclk_prev_reg) begin
      div_next = div_reg + 2'h1;
    end
    case (ck_reg)
      scd_pkg::SCD_CK_DIV1: cko_next = master_clk_in;
      scd_pkg::SCD_CK_DIV2: cko_next = div_reg[0];
      scd_pkg::SCD_CK_DIV4: cko_next = div_reg[1];
      scd_pkg::SCD_CK_HOLD: cko_next = hold_reg;
      default:              cko_next = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mclk_prev_reg      <= 1'b0;
      div_reg            <= 2'h0;
      card_clock_out     <= 1'b0;
      slow_clock_slopes  <= 1'b1;
      card_data_line_oe  <= 1'b0;
      aux_pin_a_strap_oe <= 1'b0;
      aux_pin_b_strap_oe <= 1'b0;
    end else begin
      mclk_prev_reg      <= master_clk_in;
      div_reg            <= div_next;
      card_clock_out     <= cko_next;
      slow_clock_slopes  <= cfg_next.slow_slopes;
      card_data_line_oe  <= sync_next;
      aux_pin_a_strap_oe <= sync_next;
      aux_pin_b_strap_oe <= sync_next;
    end
  end

  // ----------------------------------------
  // Checks.
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_prog_reset_copy: assert property (
    kind == scd_pkg::SCD_CMD_PROG |=> card_reset_out == $past(cmd_reg[4]))
    else $error("program command did not copy reset bit");
  chk_prog_supply_set: assert property (
    kind == scd_pkg::SCD_CMD_PROG |=> card_supply == $past(cmd_reg[1:0]))
    else $error("program command did not set supply");
  chk_strap_miss_ignored: assert property (
    valid_reg && !single_slot_bank && !cmd_reg[7] &&
    cmd_reg[6:5] != {aux_pin_b_strap_in, aux_pin_a_strap_in}
    |=> $stable(card_supply) && $stable(card_reset_out))
    else $error("unaddressed command took effect");
  chk_sync_pins_driven: assert property (
    kind == scd_pkg::SCD_CMD_SYNC |=> aux_pin_a_strap_out == $past(cmd_reg[1])
    && aux_pin_b_strap_out == $past(cmd_reg[0]) ##1 aux_pin_a_strap_oe)
    else $error("sync command did not drive pins");
  chk_cfg_reset_low: assert property (
    kind == scd_pkg::SCD_CMD_CFG |=> !card_reset_out)
    else $error("card reset not low during configuration");
  chk_rsv_cfg_kept: assert property (
    kind == scd_pkg::SCD_CMD_RSV |=> $stable(cfg_reg))
    else $error("reserved command changed configuration");
  chk_clock_low_held: assert property (
    ck_reg == scd_pkg::SCD_CK_LOW && $past(ck_reg) == scd_pkg::SCD_CK_LOW
    |-> !card_clock_out)
    else $error("card clock not held low");
  chk_miso_released: assert property (
    spi_cs_n |=> !spi_miso_oe)
    else $error("serial output driven while deselected");
  chk_shift_edge_mode: assert property (
    !spi_cs_n && !cs_prev_reg && tx_next != tx_reg |-> shift_edge)
    else $error("readback shifted on wrong edge");
  chk_byte_then_act: assert property (
    valid_reg |-> $past(cnt_reg) == 3'h7 && $past(sample_edge))
    else $error("command acted before eight bits");

  cov_prog_cmd: cover property (kind == scd_pkg::SCD_CMD_PROG);
  cov_sync_cmd: cover property (kind == scd_pkg::SCD_CMD_SYNC);
  cov_cfg_normal: cover property (kind == scd_pkg::SCD_CMD_CFG ##1 !cfg_reg.edge_special);
  cov_rsv_cmd: cover property (kind == scd_pkg::SCD_CMD_RSV);

endmodule : scd_decoder

// ===== scd_host.sv
// Host model: serial bus master that sends command bytes and collects readback.
// Assumes the bench calls xfer and tells it which edge mode the device is in.
module scd_host (
  input  wire logic clk,
  input  wire logic normal_mode,
  output logic      spi_cs_n,
  output logic      spi_clk,
  output logic      spi_mosi,
  input  wire logic spi_miso,
  input  wire logic spi_miso_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    spi_cs_n = 1'b1;
    spi_clk  = 1'b1;
    spi_mosi = 1'b0;
  end

  // ----------------------------------------
  // One frame, MSB first, readback taken before each sample edge
  // ----------------------------------------
  task automatic xfer(input logic [7:0] cmd, input int nbits, output logic [7:0] rb,
                      output logic [7:0] oe);
    rb = 8'h00;
    oe = 8'h00;
    spi_clk = ~normal_mode;
    repeat (4) @(negedge clk);
    spi_cs_n = 1'b0;
    repeat (3) @(negedge clk);
    for (int i = 0; i < nbits; i++) begin
      spi_mosi = cmd[7-i];
      repeat (4) @(negedge clk);
      rb[7-i] = spi_miso_oe & spi_miso;
      oe[7-i] = spi_miso_oe;
      spi_clk = ~spi_clk;
      repeat (4) @(negedge clk);
      spi_clk = ~spi_clk;
    end
    repeat (4) @(negedge clk);
    spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
  endtask : xfer
endmodule : scd_host

// ===== test_smart_card_serial_command_decoder.sv
// Testbench of the smart card serial command decoder.
// Assumes scd_decoder and scd_host are compiled first.
module test_smart_card_serial_command_decoder;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk, rst, cs_n, sclk, mosi, miso, miso_oe, single, mclk, det, pwr;
  logic       crst, cclk, slow, d_out, d_oe, a_out, a_oe, b_out, b_oe;
  logic       d_drv, a_drv, b_drv, nm;
  logic [1:0] sup;
  logic [7:0] rb, oe;
  int         mismatches, check_count, cyc, n;

  // ----------------------------------------
  // Pin levels seen by all parties
  // ----------------------------------------
  wire d_w = d_oe ? d_out : d_drv;
  wire a_w = a_oe ? a_out : a_drv;
  wire b_w = b_oe ? b_out : b_drv;

  scd_decoder dut (
    .clk(clk), .rst(rst), .spi_cs_n(cs_n), .spi_clk(sclk), .spi_mosi(mosi),
    .spi_miso(miso), .spi_miso_oe(miso_oe), .single_slot_bank(single),
    .master_clk_in(mclk), .card_detect_in(det), .power_ok_in(pwr),
    .card_reset_out(crst), .card_clock_out(cclk), .card_supply(sup),
    .slow_clock_slopes(slow), .card_data_line_in(d_w), .card_data_line_out(d_out),
    .card_data_line_oe(d_oe), .aux_pin_a_strap_in(a_w), .aux_pin_a_strap_out(a_out),
    .aux_pin_a_strap_oe(a_oe), .aux_pin_b_strap_in(b_w), .aux_pin_b_strap_out(b_out),
    .aux_pin_b_strap_oe(b_oe)
  );

  scd_host host (
    .clk(clk), .normal_mode(nm), .spi_cs_n(cs_n), .spi_clk(sclk), .spi_mosi(mosi),
    .spi_miso(miso), .spi_miso_oe(miso_oe)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    mclk = 1'b0;
    forever begin
      repeat (4) @(negedge clk);
      mclk = ~mclk;
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wrap_up();
    if (mismatches == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  task automatic send(input logic [7:0] cmd);
    host.xfer(cmd, 8, rb, oe);
    repeat (6) @(negedge clk);
  endtask : send

  task automatic count_toggles(output int t);
    logic p;
    t = 0;
    p = cclk;
    repeat (64) begin
      @(negedge clk);
      if (cclk !== p) t++;
      p = cclk;
    end
  endtask : count_toggles

  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      mismatches++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1; single = 1'b0; det = 1'b1; pwr = 1'b1; nm = 1'b0;
    d_drv = 1'b0; a_drv = 1'b1; b_drv = 1'b0;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check("defaults", {1'b0, miso_oe, d_oe, a_oe, crst, cclk, sup}, 8'h00);
    check("slow_default", 8'(slow), 8'h01);
    send(8'h40);
    check("rb_first", rb & 8'h1f, 8'h15);
    check("rb_oe", oe, 8'h1f);
    check("strap_miss", {6'h0, sup}, 8'h00);
    for (int k = 0; k < 4; k++) begin
      send({3'h1, 1'b1, 2'(k), 2'(k)});
      check("supply", {6'h0, sup}, 8'(k));
      check("reset_copy", 8'(crst), 8'h01);
      count_toggles(n);
      check("clk_rate", 8'((k == 0) ? (n == 0) : (n >= (16 >> (k - 1)) - 1 &&
            n <= (16 >> (k - 1)) + 1)), 8'h01);
    end
    send(8'h80);
    check("shared_100", {5'h0, crst, sup}, 8'h07);
    host.xfer(8'h20, 4, rb, oe);
    repeat (6) @(negedge clk);
    check("partial", {5'h0, crst, sup}, 8'h07);
    send(8'ha5);
    check("fast_rst", {6'h0, slow, crst}, 8'h00);
    send(8'hbf);
    check("rsv_cfg", 8'(slow), 8'h00);
    send(8'ha4);
    check("slow_set", 8'(slow), 8'h01);
    send(8'hf0);
    check("rsv_reset", {6'h0, slow, crst}, 8'h03);
    send(8'ha1);
    send(8'ha3);
    nm = 1'b1;
    send(8'he0);
    check("nc_in", rb & 8'h10, 8'h10);
    det = 1'b0;
    d_drv = 1'b1;
    send(8'he0);
    send(8'he0);
    check("nc_out", rb & 8'h1f, 8'h0d);
    send(8'ha0);
    send(8'he0);
    check("no_in", rb & 8'h10, 8'h10);
    send(8'ha2);
    nm = 1'b0;
    send(8'he0);
    check("raw_det", rb & 8'h10, 8'h00);
    single = 1'b1;
    send(8'h00);
    check("single_0xx", {6'h0, sup}, 8'h03);
    send(8'h95);
    count_toggles(n);
    check("single_prog", {4'h0, crst, 1'(n >= 15 && n <= 17), sup}, 8'h0d);
    send(8'hd3);
    check("sync_pins", {1'b0, d_oe, a_oe, crst, cclk, d_out, a_out, b_out}, 8'h73);
    pwr = 1'b0;
    send(8'hd8);
    check("sync_rb", rb & 8'h1f, 8'h06);
    check("sync_pins2", {2'h0, b_oe, crst, cclk, d_out, a_out, b_out}, 8'h38);
    wrap_up();
  end
endmodule : test_smart_card_serial_command_decoder
